// [common/rce_pkg.sv]
// Constants shared by the relay command executor and its terminator encoder.
// Assumes a single 200 MHz clock with a synchronous active-high reset.
package rce_pkg;
  localparam int          XP_W         = 64;
  localparam int          IDX_W        = 7;
  localparam int          SLOT_COUNT   = 101;
  localparam logic [6:0]  IDX_RELAYS   = 7'h00;
  localparam logic [6:0]  IDX_MAX      = 7'h64;
  localparam logic [6:0]  STEP_RESET   = 7'h00;

  localparam logic [2:0]  OP_PTR          = 3'h0;
  localparam logic [2:0]  OP_CUT          = 3'h1;
  localparam logic [2:0]  OP_JOIN         = 3'h2;
  localparam logic [2:0]  OP_ALL_OFF      = 3'h3;
  localparam logic [2:0]  OP_COPY         = 3'h4;
  localparam logic [2:0]  OP_LINE_END     = 3'h5;
  localparam logic [2:0]  OP_FULL_DEFAULT = 3'h6;

  localparam logic [1:0]  LES_CR_LF     = 2'h0;
  localparam logic [1:0]  LES_LF_CR     = 2'h1;
  localparam logic [1:0]  LES_CR        = 2'h2;
  localparam logic [1:0]  LES_LF        = 2'h3;
  localparam logic [1:0]  LES_DEFAULT   = 2'h0;
  localparam logic [7:0]  CHAR_CR       = 8'h0d;
  localparam logic [7:0]  CHAR_LF       = 8'h0a;
  localparam logic [7:0]  CHAR_NONE     = 8'h00;
  localparam logic [1:0]  TERM_LEN_ONE  = 2'h1;
  localparam logic [1:0]  TERM_LEN_TWO  = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_APPLY = 3'b010,
    ST_DONE  = 3'b100
  } rce_state_t;
endpackage

// [rtl/rce_term_enc.sv]
// Terminator encoder: turns the line-end selection into the one or two characters sent after output data.
// Assumes the selection is already a registered value in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module rce_term_enc (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic [1:0] sel_in,
  output logic      [7:0] first_out,
  output logic      [7:0] second_out,
  output logic      [1:0] len_out
);
  logic [7:0] first_q;
  logic [7:0] first_d;
  logic [7:0] second_q;
  logic [7:0] second_d;
  logic [1:0] len_q;
  logic [1:0] len_d;

  always_comb begin
    case (sel_in)
      rce_pkg::LES_CR_LF: begin
        first_d  = rce_pkg::CHAR_CR;
        second_d = rce_pkg::CHAR_LF;
        len_d    = rce_pkg::TERM_LEN_TWO;
      end
      rce_pkg::LES_LF_CR: begin
        first_d  = rce_pkg::CHAR_LF;
        second_d = rce_pkg::CHAR_CR;
        len_d    = rce_pkg::TERM_LEN_TWO;
      end
      rce_pkg::LES_CR: begin
        first_d  = rce_pkg::CHAR_CR;
        second_d = rce_pkg::CHAR_NONE;
        len_d    = rce_pkg::TERM_LEN_ONE;
      end
      default: begin
        first_d  = rce_pkg::CHAR_LF;
        second_d = rce_pkg::CHAR_NONE;
        len_d    = rce_pkg::TERM_LEN_ONE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      first_q  <= rce_pkg::CHAR_CR;
      second_q <= rce_pkg::CHAR_LF;
      len_q    <= rce_pkg::TERM_LEN_TWO;
    end else begin
      first_q  <= first_d;
      second_q <= second_d;
      len_q    <= len_d;
    end
  end

  assign first_out  = first_q;
  assign second_out = second_q;
  assign len_out    = len_q;
endmodule
`default_nettype wire

// [rtl/rce_executor.sv]
// Relay command executor: buffers parsed commands and applies them as one batch on the run marker.
// Assumes an upstream parser delivers one decoded command per CMD_VALID_IN pulse.
//
// Contract
// - The run marker executes exactly the commands received since the previous marker.
// - Commands without a marker are held in a buffer, not acted on.
// - A marker in a later transfer executes commands buffered earlier.
// - The marker also raises a trigger when that trigger source is chosen.
// - Line-end select picks CR LF, LF CR, CR, or LF terminator.
// - Reset, device clear or full default restores line-end select to CR LF.
// - Setup copy moves slot source to slot destination; slot 0 is the relays.
// - Copying a stored setup onto relays sets the step pointer to its source.
// - Copy zero to zero leaves relays alone and zeroes the step pointer.
// - Pointer-zero cut and join, all off zero, copy to relays change relays.
// - Relay-affecting commands in one batch give one switching operation.
// - Precedence is pointer, all off, copy, cut, join; later stages win.
// - A cut crosspoint never closes momentarily; only the merged state is driven.
// - The bus is held off from the marker until configuration completes.
`timescale 1ns/1ps
`default_nettype none
module rce_executor (
  // Clock and reset.
  input  wire logic        CLK_SYS_IN,
  input  wire logic        SRST_IN,
  // Decoded command stream.
  input  wire logic        CMD_VALID_IN,
  input  wire logic [2:0]  CMD_OP_IN,
  input  wire logic [6:0]  CMD_ARG_A_IN,
  input  wire logic [6:0]  CMD_ARG_B_IN,
  input  wire logic [63:0] CMD_MASK_IN,
  input  wire logic        RUN_MARKER_IN,
  input  wire logic        DEV_CLEAR_IN,
  input  wire logic        TRIG_SRC_MARKER_IN,
  // Status towards the bus side.
  output logic             CMD_READY_OUT,
  output logic             HOLDOFF_OUT,
  output logic             TRIGGER_OUT,
  // Relay drive and pointers.
  output logic      [63:0] RELAY_STATE_OUT,
  output logic             RELAY_LOAD_OUT,
  output logic      [6:0]  STEP_PTR_OUT,
  output logic      [6:0]  EDIT_PTR_OUT,
  // Output terminator.
  output logic      [1:0]  LINE_END_SELECT_OUT,
  output logic      [7:0]  TERM_FIRST_OUT,
  output logic      [7:0]  TERM_SECOND_OUT,
  output logic      [1:0]  TERM_LEN_OUT
);
  localparam int XW = rce_pkg::XP_W;
  localparam int IW = rce_pkg::IDX_W;

  rce_pkg::rce_state_t state_q;
  rce_pkg::rce_state_t state_d;

  // Pending batch: each command folds into its precedence stage as it arrives.
  logic          p_ptr_q,  p_ptr_d;
  logic [IW-1:0] p_ptr_idx_q, p_ptr_idx_d;
  logic          p_off_q,  p_off_d;
  logic [IW-1:0] p_off_idx_q, p_off_idx_d;
  logic          p_copy_q, p_copy_d;
  logic [IW-1:0] p_src_q,  p_src_d;
  logic [IW-1:0] p_dst_q,  p_dst_d;
  logic [XW-1:0] p_cut_q,  p_cut_d;
  logic [XW-1:0] p_join_q, p_join_d;
  logic          p_les_q,  p_les_d;
  logic [1:0]    p_les_v_q, p_les_v_d;
  logic          p_dflt_q, p_dflt_d;

  logic [XW-1:0] mem_q [rce_pkg::SLOT_COUNT];
  logic [XW-1:0] mem_d [rce_pkg::SLOT_COUNT];
  logic [XW-1:0] relay_q, relay_d;
  logic          load_q,  load_d;
  logic [IW-1:0] step_q,  step_d;
  logic [IW-1:0] edit_q,  edit_d;
  logic [1:0]    les_q,   les_d;
  logic          hold_q,  hold_d;
  logic          ready_q, ready_d;
  logic          trig_q,  trig_d;

  logic [IW-1:0] eff_ptr;
  logic [XW-1:0] stage_relay;
  logic [XW-1:0] copy_data;
  logic          take_cmd;
  logic          take_marker;

  assign take_cmd    = CMD_VALID_IN && (state_q == rce_pkg::ST_IDLE);
  assign take_marker = RUN_MARKER_IN && (state_q == rce_pkg::ST_IDLE);

  // Batch accumulation and sequencing.
  always_comb begin
    state_d     = state_q;
    p_ptr_d     = p_ptr_q;
    p_ptr_idx_d = p_ptr_idx_q;
    p_off_d     = p_off_q;
    p_off_idx_d = p_off_idx_q;
    p_copy_d    = p_copy_q;
    p_src_d     = p_src_q;
    p_dst_d     = p_dst_q;
    p_cut_d     = p_cut_q;
    p_join_d    = p_join_q;
    p_les_d     = p_les_q;
    p_les_v_d   = p_les_v_q;
    p_dflt_d    = p_dflt_q;
    hold_d      = hold_q;
    trig_d      = 1'b0;
    if (take_cmd) begin
      case (CMD_OP_IN)
        rce_pkg::OP_PTR: begin
          p_ptr_d     = 1'b1;
          p_ptr_idx_d = CMD_ARG_A_IN;
        end
        rce_pkg::OP_CUT: begin
          p_cut_d  = p_cut_q | CMD_MASK_IN;
          p_join_d = p_join_q & ~CMD_MASK_IN;
        end
        rce_pkg::OP_JOIN: begin
          p_join_d = p_join_q | CMD_MASK_IN;
        end
        rce_pkg::OP_ALL_OFF: begin
          if (CMD_ARG_A_IN <= rce_pkg::IDX_MAX) begin
            p_off_d     = 1'b1;
            p_off_idx_d = CMD_ARG_A_IN;
          end
        end
        rce_pkg::OP_COPY: begin
          if ((CMD_ARG_A_IN <= rce_pkg::IDX_MAX) && (CMD_ARG_B_IN <= rce_pkg::IDX_MAX)) begin
            p_copy_d = 1'b1;
            p_src_d  = CMD_ARG_A_IN;
            p_dst_d  = CMD_ARG_B_IN;
          end
        end
        rce_pkg::OP_LINE_END: begin
          p_les_d   = 1'b1;
          p_les_v_d = CMD_ARG_A_IN[1:0];
        end
        rce_pkg::OP_FULL_DEFAULT: begin
          p_dflt_d = 1'b1;
        end
        default: begin
          p_dflt_d = p_dflt_q;
        end
      endcase
    end
    case (state_q)
      rce_pkg::ST_IDLE: begin
        if (take_marker) begin
          state_d = rce_pkg::ST_APPLY;
          hold_d  = 1'b1;
          trig_d  = TRIG_SRC_MARKER_IN;
        end
      end
      rce_pkg::ST_APPLY: begin
        state_d = rce_pkg::ST_DONE;
      end
      rce_pkg::ST_DONE: begin
        state_d  = rce_pkg::ST_IDLE;
        hold_d   = 1'b0;
        p_ptr_d  = 1'b0;
        p_off_d  = 1'b0;
        p_copy_d = 1'b0;
        p_cut_d  = '0;
        p_join_d = '0;
        p_les_d  = 1'b0;
        p_dflt_d = 1'b0;
      end
      default: begin
        state_d = rce_pkg::ST_IDLE;
        hold_d  = 1'b0;
      end
    endcase
    ready_d = (state_d == rce_pkg::ST_IDLE);
  end

  // Merged relay and memory computation, committed in the single apply cycle.
  always_comb begin
    eff_ptr     = p_ptr_q ? p_ptr_idx_q : edit_q;
    mem_d       = mem_q;
    relay_d     = relay_q;
    step_d      = step_q;
    edit_d      = edit_q;
    les_d       = les_q;
    load_d      = 1'b0;
    stage_relay = relay_q;
    copy_data   = '0;
    // A device clear in the apply cycle aborts the batch, so nothing reaches the relays.
    if ((state_q == rce_pkg::ST_APPLY) && !DEV_CLEAR_IN) begin
      edit_d = eff_ptr;
      if (p_off_q) begin
        if (p_off_idx_q == rce_pkg::IDX_RELAYS) begin
          stage_relay = '0;
        end else begin
          mem_d[p_off_idx_q] = '0;
        end
      end
      if (p_copy_q) begin
        copy_data = (p_src_q == rce_pkg::IDX_RELAYS) ? stage_relay : mem_d[p_src_q];
        if (p_dst_q == rce_pkg::IDX_RELAYS) begin
          stage_relay = copy_data;
          step_d      = p_src_q;
        end else begin
          mem_d[p_dst_q] = copy_data;
        end
      end
      if (eff_ptr == rce_pkg::IDX_RELAYS) begin
        stage_relay = (stage_relay & ~p_cut_q) | p_join_q;
      end else if (eff_ptr <= rce_pkg::IDX_MAX) begin
        mem_d[eff_ptr] = (mem_d[eff_ptr] & ~p_cut_q) | p_join_q;
      end
      // One registered update avoids any intermediate crosspoint state reaching the relays.
      relay_d = stage_relay;
      load_d  = p_off_q || p_copy_q || (eff_ptr == rce_pkg::IDX_RELAYS);
      if (p_les_q) begin
        les_d = p_les_v_q;
      end
      if (p_dflt_q) begin
        les_d = rce_pkg::LES_DEFAULT;
      end
    end
    if (DEV_CLEAR_IN) begin
      les_d = rce_pkg::LES_DEFAULT;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || DEV_CLEAR_IN) begin
      state_q     <= rce_pkg::ST_IDLE;
      p_ptr_q     <= 1'b0;
      p_ptr_idx_q <= rce_pkg::IDX_RELAYS;
      p_off_q     <= 1'b0;
      p_off_idx_q <= rce_pkg::IDX_RELAYS;
      p_copy_q    <= 1'b0;
      p_src_q     <= rce_pkg::IDX_RELAYS;
      p_dst_q     <= rce_pkg::IDX_RELAYS;
      p_cut_q     <= '0;
      p_join_q    <= '0;
      p_les_q     <= 1'b0;
      p_les_v_q   <= rce_pkg::LES_DEFAULT;
      p_dflt_q    <= 1'b0;
      hold_q      <= 1'b0;
      ready_q     <= 1'b1;
      trig_q      <= 1'b0;
      load_q      <= 1'b0;
    end else begin
      state_q     <= state_d;
      p_ptr_q     <= p_ptr_d;
      p_ptr_idx_q <= p_ptr_idx_d;
      p_off_q     <= p_off_d;
      p_off_idx_q <= p_off_idx_d;
      p_copy_q    <= p_copy_d;
      p_src_q     <= p_src_d;
      p_dst_q     <= p_dst_d;
      p_cut_q     <= p_cut_d;
      p_join_q    <= p_join_d;
      p_les_q     <= p_les_d;
      p_les_v_q   <= p_les_v_d;
      p_dflt_q    <= p_dflt_d;
      hold_q      <= hold_d;
      ready_q     <= ready_d;
      trig_q      <= trig_d;
      load_q      <= load_d;
    end
  end

  // Relay and stored setups survive a device clear; only reset clears them.
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      relay_q <= '0;
      step_q  <= rce_pkg::STEP_RESET;
      edit_q  <= rce_pkg::IDX_RELAYS;
      les_q   <= rce_pkg::LES_DEFAULT;
      for (int i = 0; i < rce_pkg::SLOT_COUNT; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      relay_q <= relay_d;
      step_q  <= step_d;
      edit_q  <= edit_d;
      les_q   <= les_d;
      for (int i = 0; i < rce_pkg::SLOT_COUNT; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  rce_term_enc u_term_enc (
    .clk_in     (CLK_SYS_IN),
    .srst_in    (SRST_IN),
    .sel_in     (les_q),
    .first_out  (TERM_FIRST_OUT),
    .second_out (TERM_SECOND_OUT),
    .len_out    (TERM_LEN_OUT)
  );

  assign CMD_READY_OUT       = ready_q;
  assign HOLDOFF_OUT         = hold_q;
  assign TRIGGER_OUT         = trig_q;
  assign RELAY_STATE_OUT     = relay_q;
  assign RELAY_LOAD_OUT      = load_q;
  assign STEP_PTR_OUT        = step_q;
  assign EDIT_PTR_OUT        = edit_q;
  assign LINE_END_SELECT_OUT = les_q;
endmodule
`default_nettype wire

// [tb/rce_ctrl_model.sv]
// Bus controller model: puts decoded commands and run markers on the executor inputs.
// Assumes its task is called by the bench at a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module rce_ctrl_model (
  // Clock.
  input  wire logic        clk_in,
  // Command stream.
  output logic             valid_out,
  output logic             marker_out,
  output logic      [2:0]  op_out,
  output logic      [6:0]  arg_a_out,
  output logic      [6:0]  arg_b_out,
  output logic      [63:0] mask_out
);
  initial begin
    valid_out = 1'b0;
    marker_out = 1'b0;
    {op_out, arg_a_out, arg_b_out, mask_out} = '1;
  end
  // Released fields are inverted, so nothing can lean on stale values.
  task automatic send(input logic [2:0] o, input logic [6:0] a, input logic [6:0] b,
                      input logic [63:0] m, input logic run);
    @(negedge clk_in);
    valid_out = ~run;
    marker_out = run;
    {op_out, arg_a_out, arg_b_out, mask_out} = {o, a, b, m};
    @(negedge clk_in);
    valid_out = 1'b0;
    marker_out = 1'b0;
    {op_out, arg_a_out, arg_b_out, mask_out} = ~{o, a, b, m};
  endtask
endmodule
`default_nettype wire

// [tb/rce_executor_properties.sv]
// Port-level checker for the relay command executor.
// Assumes it is bound into rce_executor and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module rce_executor_properties (
  input wire logic        CLK_SYS_IN,
  input wire logic        SRST_IN,
  input wire logic        RUN_MARKER_IN,
  input wire logic        DEV_CLEAR_IN,
  input wire logic        TRIG_SRC_MARKER_IN,
  input wire logic        CMD_READY_OUT,
  input wire logic        HOLDOFF_OUT,
  input wire logic        TRIGGER_OUT,
  input wire logic [63:0] RELAY_STATE_OUT,
  input wire logic        RELAY_LOAD_OUT,
  input wire logic [6:0]  STEP_PTR_OUT,
  input wire logic [1:0]  LINE_END_SELECT_OUT,
  input wire logic [7:0]  TERM_FIRST_OUT,
  input wire logic [7:0]  TERM_SECOND_OUT,
  input wire logic [1:0]  TERM_LEN_OUT
);
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (SRST_IN);
  sequence s_taken;
    RUN_MARKER_IN && CMD_READY_OUT && !DEV_CLEAR_IN;
  endsequence
  sequence s_busy;
    (HOLDOFF_OUT && !CMD_READY_OUT)[*2] ##1 (CMD_READY_OUT && !HOLDOFF_OUT);
  endsequence
  a_marker_holdoff: assert property (s_taken |=> s_busy)
    else $error("hold-off window wrong");
  a_trigger_cause: assert property (TRIGGER_OUT |-> $past(RUN_MARKER_IN)
    && $past(CMD_READY_OUT) && $past(TRIG_SRC_MARKER_IN)) else $error("stray trigger");
  a_load_once: assert property (RELAY_LOAD_OUT |=> !RELAY_LOAD_OUT)
    else $error("load longer than one cycle");
  a_load_in_busy: assert property (RELAY_LOAD_OUT |-> HOLDOFF_OUT && $past(HOLDOFF_OUT))
    else $error("load outside execution");
  a_relay_by_load: assert property ($changed(RELAY_STATE_OUT) |-> RELAY_LOAD_OUT)
    else $error("relays moved without load");
  a_step_in_busy: assert property ($changed(STEP_PTR_OUT) |-> RELAY_LOAD_OUT)
    else $error("step pointer moved outside load");
  a_term_crlf: assert property ($past(LINE_END_SELECT_OUT) == rce_pkg::LES_CR_LF
    |-> {TERM_FIRST_OUT, TERM_SECOND_OUT, TERM_LEN_OUT} ==
    {rce_pkg::CHAR_CR, rce_pkg::CHAR_LF, rce_pkg::TERM_LEN_TWO}) else $error("bad CR LF");
  a_term_lf: assert property ($past(LINE_END_SELECT_OUT) == rce_pkg::LES_LF
    |-> TERM_FIRST_OUT == rce_pkg::CHAR_LF && TERM_LEN_OUT == rce_pkg::TERM_LEN_ONE)
    else $error("bad LF only");
  a_clear_line_end: assert property (DEV_CLEAR_IN |=> LINE_END_SELECT_OUT == 2'h0)
    else $error("clear kept line end");
endmodule
bind rce_executor rce_executor_properties u_rce_executor_properties (.CLK_SYS_IN, .SRST_IN,
  .RUN_MARKER_IN, .DEV_CLEAR_IN, .TRIG_SRC_MARKER_IN, .CMD_READY_OUT, .HOLDOFF_OUT,
  .TRIGGER_OUT, .RELAY_STATE_OUT, .RELAY_LOAD_OUT, .STEP_PTR_OUT, .LINE_END_SELECT_OUT,
  .TERM_FIRST_OUT, .TERM_SECOND_OUT, .TERM_LEN_OUT);
`default_nettype wire

// [tb/rce_executor_tb.sv]
// Self-checking bench for the relay command executor.
// Assumes the controller model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module rce_executor_tb;
  typedef struct {
    logic [63:0] rel;
    logic [6:0]  step;
    logic [6:0]  edit;
    logic [1:0]  les;
    int          nload;
    int          ntrig;
  } rce_exp_t;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        dclr = 1'b0;
  logic        tsrc = 1'b0;
  logic        vld, mk, rdy, hold, trg, load;
  logic [2:0]  op;
  logic [6:0]  aa, bb, step, edit;
  logic [63:0] msk, rel, m_rel, cutm, joinm;
  logic [63:0] slot [0:100];
  logic [1:0]  les, tlen;
  logic [7:0]  t1, t2;
  logic        hq = 1'b0;
  int          m_step, m_edit, m_les, p_ptr, p_off, p_src, p_dst, p_les, p_dflt;
  int          seed = 32'hf64e;
  int          n_mismatch = 0, num_checks = 0, nl = 0, nt = 0;
  rce_exp_t    expq [$];
  always #2.5 clk = ~clk;
  rce_ctrl_model u_rce_ctrl_model (.clk_in(clk), .valid_out(vld), .marker_out(mk),
    .op_out(op), .arg_a_out(aa), .arg_b_out(bb), .mask_out(msk));
  rce_executor u_rce_executor (.CLK_SYS_IN(clk), .SRST_IN(srst), .CMD_VALID_IN(vld),
    .CMD_OP_IN(op), .CMD_ARG_A_IN(aa), .CMD_ARG_B_IN(bb), .CMD_MASK_IN(msk),
    .RUN_MARKER_IN(mk), .DEV_CLEAR_IN(dclr), .TRIG_SRC_MARKER_IN(tsrc),
    .CMD_READY_OUT(rdy), .HOLDOFF_OUT(hold), .TRIGGER_OUT(trg), .RELAY_STATE_OUT(rel),
    .RELAY_LOAD_OUT(load), .STEP_PTR_OUT(step), .EDIT_PTR_OUT(edit),
    .LINE_END_SELECT_OUT(les), .TERM_FIRST_OUT(t1), .TERM_SECOND_OUT(t2),
    .TERM_LEN_OUT(tlen));
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_batch(input rce_exp_t x);
    logic [17:0] t;
    case (x.les)
      2'h0: t = {rce_pkg::CHAR_CR, rce_pkg::CHAR_LF, rce_pkg::TERM_LEN_TWO};
      2'h1: t = {rce_pkg::CHAR_LF, rce_pkg::CHAR_CR, rce_pkg::TERM_LEN_TWO};
      2'h2: t = {rce_pkg::CHAR_CR, rce_pkg::CHAR_NONE, rce_pkg::TERM_LEN_ONE};
      default: t = {rce_pkg::CHAR_LF, rce_pkg::CHAR_NONE, rce_pkg::TERM_LEN_ONE};
    endcase
    chk(rel === x.rel && step === x.step && edit === x.edit, "relays or pointers");
    chk(les === x.les && {t1, t2, tlen} === t, "terminator");
    chk(nl == x.nload && nt == x.ntrig, "load or trigger count");
  endtask
  task automatic clear_pend();
    {p_ptr, p_off, p_src, p_dst, p_les, p_dflt} = {6{-32'sd1}};
    cutm = '0;
    joinm = '0;
  endtask
  task automatic cmd(input logic [2:0] o, input logic [6:0] a, input logic [6:0] b,
                     input logic [63:0] m);
    case (o)
      3'h0: p_ptr = a;
      3'h1: begin
        cutm |= m;
        joinm &= ~m;
      end
      3'h2: joinm |= m;
      3'h3: if (a <= rce_pkg::IDX_MAX) p_off = a;
      3'h4: if (a <= rce_pkg::IDX_MAX && b <= rce_pkg::IDX_MAX) begin
        p_src = a;
        p_dst = b;
      end
      3'h5: p_les = a[1:0];
      3'h6: p_dflt = 0;
      default: ;
    endcase
    u_rce_ctrl_model.send(o, a, b, m, 1'b0);
  endtask
  // The model applies stages in the fixed order so later stages win per crosspoint.
  task automatic run();
    rce_exp_t    x;
    logic [63:0] v;
    int          e;
    e = (p_ptr >= 0) ? p_ptr : m_edit;
    m_edit = e;
    x.nload = (p_off >= 0 || p_src >= 0 || e == 0) ? 1 : 0;
    x.ntrig = (tsrc === 1'b1) ? 1 : 0;
    if (p_off == 0) m_rel = '0;
    else if (p_off > 0) slot[p_off] = '0;
    if (p_src >= 0) begin
      v = (p_src == 0) ? m_rel : slot[p_src];
      if (p_dst == 0) begin
        m_rel = v;
        m_step = p_src;
      end else slot[p_dst] = v;
    end
    if (e == 0) m_rel = (m_rel & ~cutm) | joinm;
    else slot[e] = (slot[e] & ~cutm) | joinm;
    if (p_les >= 0) m_les = p_les;
    // The full default wins over a line-end command in the same batch.
    if (p_dflt >= 0) m_les = rce_pkg::LES_DEFAULT;
    x.rel = m_rel;
    x.edit = 7'(e);
    x.step = 7'(m_step);
    x.les = 2'(m_les);
    expq.push_back(x);
    clear_pend();
    u_rce_ctrl_model.send(3'h0, 7'h00, 7'h00, '0, 1'b1);
    for (int i = 0; i < 20 && rdy !== 1'b1; i++) @(negedge clk);
    if (rdy !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH at %0t: executor stayed busy", $time);
      stop_test();
    end
  endtask
  always @(negedge clk) begin
    if (srst) {nl, nt, hq} = '0;
    else begin
      if (load === 1'b1) nl++;
      if (trg === 1'b1) nt++;
      if (hq && hold === 1'b0) begin
        if (expq.size() == 0) chk(1'b0, "unexpected batch end");
        else chk_batch(expq.pop_front());
        nl = 0;
        nt = 0;
      end
      hq = hold;
    end
  end
  initial begin
    {m_rel, m_step, m_edit, m_les} = '0;
    foreach (slot[i]) slot[i] = '0;
    clear_pend();
    repeat (6) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      cmd(3'h5, 7'(i), 7'h00, '0);
      run();
    end
    cmd(3'h6, 7'h00, 7'h00, '0);
    run();
    cmd(3'h5, 7'h03, 7'h00, '0);
    run();
    cmd(3'h2, 7'h00, 7'h00, '1);
    @(negedge clk) dclr = 1'b1;
    @(negedge clk) dclr = 1'b0;
    m_les = 0;
    clear_pend();
    run();
    cmd(3'h0, 7'h05, 7'h00, '0);
    cmd(3'h2, 7'h00, 7'h00, 64'h8000_0000_0000_00f1);
    run();
    cmd(3'h0, 7'h00, 7'h00, '0);
    cmd(3'h4, 7'h05, 7'h00, '0);
    cmd(3'h1, 7'h00, 7'h00, 64'h1);
    cmd(3'h2, 7'h00, 7'h00, 64'h2);
    repeat (8) @(negedge clk);
    run();
    cmd(3'h3, 7'h00, 7'h00, '0);
    cmd(3'h2, 7'h00, 7'h00, 64'h4);
    run();
    cmd(3'h4, 7'h00, 7'h00, '0);
    run();
    cmd(3'h4, 7'h65, 7'h00, '0);
    cmd(3'h4, 7'h00, 7'h65, '0);
    run();
    cmd(3'h0, 7'h09, 7'h00, '0);
    cmd(3'h4, 7'h00, 7'h07, '0);
    run();
    run();
    for (int k = 0; k < 60; k++) begin
      tsrc = 1'($random(seed));
      repeat ({$random(seed)} % 4) cmd(3'({$random(seed)} % 8), 7'({$random(seed)} % 101),
        7'({$random(seed)} % 102), {$random(seed), $random(seed)});
      run();
    end
    stop_test();
  end
endmodule
`default_nettype wire
